// File: conn_req_defines.svh
`ifndef CONN_REQ_DEFINES_SVH
`define CONN_REQ_DEFINES_SVH

// ==========================================
// Word layout
`define CRW_WORD_W 32
`define CRW_LOCAL_BIT 31
`define CRW_VU_HI 30
`define CRW_VU_LO 29
`define CRW_WIDTH_BIT 28
`define CRW_DIR_BIT 27
`define CRW_PS_HI 26
`define CRW_PS_LO 25
`define CRW_CAMP_BIT 24
`define CRW_ROUTE_HI 23
`define CRW_ROUTE_W 24
`define CRW_ADDR_W 12
`define CRW_DEST_HI 23
`define CRW_DEST_LO 12
`define CRW_SRC_HI 11

// ==========================================
// Reset values
`define CRW_RESET_WORD 32'h0000_0000

`endif

// File: conn_req_pkg.sv
`include "conn_req_defines.svh"

package conn_req_pkg;

  // ==========================================
  // Path selection codes
  typedef enum logic [1:0] {
    PS_SOURCE = 2'h0,
    PS_LOGICAL_FIRST = 2'h1,
    PS_RESERVED = 2'h2,
    PS_LOGICAL_SWITCH = 2'h3
  } path_sel_e;

  // ==========================================
  // Decoded parts of a request word
  typedef struct packed {
    logic localFmt;
    logic [1:0] vendorBits;
    logic wide;
    logic dirMsb;
    path_sel_e pathSel;
    logic campOn;
    logic [`CRW_ROUTE_W-1:0] routing;
    logic [`CRW_ADDR_W-1:0] destAddr;
    logic [`CRW_ADDR_W-1:0] srcAddr;
    logic pathError;
  } req_fields_s;

  // ==========================================
  // Whole state of the codec
  typedef struct packed {
    logic [`CRW_WORD_W-1:0] cfgWord;
    logic wideMeta;
    logic wideSync;
    logic reqValid;
    logic [`CRW_WORD_W-1:0] reqWord;
    req_fields_s fields;
  } codec_state_s;

endpackage

// File: conn_req_field_decode.sv
`timescale 1ns/10ps
`include "conn_req_defines.svh"

module conn_req_field_decode (
  // Word in
  input wire logic [`CRW_WORD_W-1:0] word,
  // Parts out
  output conn_req_pkg::req_fields_s fields
);

  always_comb begin
    fields = '0;
    fields.localFmt = word[`CRW_LOCAL_BIT];
    // Private layout: nothing below the format bit is interpreted
    if (!word[`CRW_LOCAL_BIT]) begin
      fields.vendorBits = word[`CRW_VU_HI:`CRW_VU_LO];
      fields.wide = word[`CRW_WIDTH_BIT];
      fields.dirMsb = word[`CRW_DIR_BIT];
      fields.pathSel = conn_req_pkg::path_sel_e'(word[`CRW_PS_HI:`CRW_PS_LO]);
      fields.campOn = word[`CRW_CAMP_BIT];
      fields.routing = word[`CRW_ROUTE_HI:0];
      // Logical split only means something in the two logical path modes, not source routing or reserved
      if (fields.pathSel == conn_req_pkg::PS_LOGICAL_FIRST ||
          fields.pathSel == conn_req_pkg::PS_LOGICAL_SWITCH) begin
        fields.destAddr = word[`CRW_DEST_HI:`CRW_DEST_LO];
        fields.srcAddr = word[`CRW_SRC_HI:0];
      end
      fields.pathError = (fields.pathSel == conn_req_pkg::PS_RESERVED);
    end
  end

endmodule // conn_req_field_decode

// File: connection_request_field_codec.sv
`timescale 1ns/10ps
`include "conn_req_defines.svh"

// Function
// - Every connection request leaves with one 32-bit routing and control word.
// - Bit 31 set means private layout; standard fields are then not decoded.
// - Bit 28 tells the source data bus width: 0 for 32, 1 for 64.
// - Bits 23:0 carry the routing field, hop list in source routing.
// - The loaded word goes out with each request until reloaded, unaltered but for bit 28, which follows the strap in the standard layout.
module connection_request_field_codec #(
  parameter int WORD_W = `CRW_WORD_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Configuration load
  input wire logic loadValid,
  input wire logic [`CRW_WORD_W-1:0] loadWord,
  // Source bus width strap, from a pin
  input wire logic busWide,
  // Connection request
  input wire logic connReq,
  // Outgoing word and its parts
  output logic reqValid,
  output logic [`CRW_WORD_W-1:0] reqWord,
  output conn_req_pkg::req_fields_s reqFields
);

  // ==========================================
  // Elaboration check
  if (WORD_W != `CRW_WORD_W) begin : gWidthCheck
    $error("connection request word must be 32 bits");
  end

  // ==========================================
  // State
  conn_req_pkg::codec_state_s state_r;
  conn_req_pkg::codec_state_s state_nxt;
  logic [`CRW_WORD_W-1:0] sendWord;
  conn_req_pkg::req_fields_s sendFields;

  // Width bit follows the strap only in the standard layout; a private word
  // is left exactly as loaded since its bit 28 may mean something else.
  always_comb begin
    sendWord = state_r.cfgWord;
    if (!state_r.cfgWord[`CRW_LOCAL_BIT]) begin
      sendWord[`CRW_WIDTH_BIT] = state_r.wideSync;
    end
  end

  conn_req_field_decode u_conn_req_field_decode (
    .word(sendWord),
    .fields(sendFields)
  );

  always_comb begin
    state_nxt = state_r;
    state_nxt.wideMeta = busWide;
    state_nxt.wideSync = state_r.wideMeta;
    // A load in the same cycle as a request takes effect from the next one
    if (loadValid) begin
      state_nxt.cfgWord = loadWord;
    end
    state_nxt.reqValid = connReq;
    if (connReq) begin
      state_nxt.reqWord = sendWord;
      state_nxt.fields = sendFields;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= '0;
      state_r.cfgWord <= `CRW_RESET_WORD;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reqValid = state_r.reqValid;
  assign reqWord = state_r.reqWord;
  assign reqFields = state_r.fields;

  // ==========================================
  // Checks
  logic [`CRW_WORD_W-1:0] lastLoad;
  logic loadSeen;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lastLoad <= `CRW_RESET_WORD;
      loadSeen <= 1'b0;
    end else if (loadValid) begin
      lastLoad <= loadWord;
      loadSeen <= 1'b1;
    end
  end

  sequence reqTaken_q;
    connReq;
  endsequence

  sequence wordOut_q;
    ##1 reqValid;
  endsequence

  property reqGetsWord_p;
    @(posedge core_clk) disable iff (srst) reqTaken_q |-> wordOut_q;
  endproperty

  every_request_a: assert property (reqGetsWord_p)
    else $error("request without outgoing word");

  no_spurious_a: assert property (@(posedge core_clk) disable iff (srst)
    reqValid |-> $past(connReq))
    else $error("word sent without request");

  local_untouched_a: assert property (@(posedge core_clk) disable iff (srst)
    (connReq && !loadValid && lastLoad[`CRW_LOCAL_BIT] && loadSeen)
      |=> reqWord == $past(lastLoad))
    else $error("private word altered");

  width_bit_a: assert property (@(posedge core_clk) disable iff (srst)
    (reqValid && !reqWord[`CRW_LOCAL_BIT])
      |-> reqWord[`CRW_WIDTH_BIT] == $past(state_r.wideSync))
    else $error("width bit disagrees with bus strap");

  std_unaltered_a: assert property (@(posedge core_clk) disable iff (srst)
    (connReq && !loadValid && !lastLoad[`CRW_LOCAL_BIT] && loadSeen)
      |=> reqWord[`CRW_WIDTH_BIT-1:0] == $past(lastLoad[`CRW_WIDTH_BIT-1:0]))
    else $error("standard word altered below width bit");

  local_no_decode_a: assert property (@(posedge core_clk) disable iff (srst)
    reqValid && reqFields.localFmt |-> reqFields.routing == '0 && !reqFields.pathError)
    else $error("private word decoded");

  route_field_a: assert property (@(posedge core_clk) disable iff (srst)
    reqValid && !reqWord[`CRW_LOCAL_BIT]
      |-> reqFields.routing == reqWord[`CRW_ROUTE_HI:0])
    else $error("routing field mismatch");

  word_holds_a: assert property (@(posedge core_clk) disable iff (srst)
    !connReq |=> reqWord == $past(reqWord))
    else $error("outgoing word changed without request");

  // ==========================================
  // Field decode, reset and load checks
  logic stdOut;
  assign stdOut = reqValid && !reqWord[`CRW_LOCAL_BIT];

  fmt_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    reqValid |-> reqFields.localFmt == reqWord[`CRW_LOCAL_BIT])
    else $error("format flag mismatch");

  vendor_field_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut |-> reqFields.vendorBits == reqWord[`CRW_VU_HI:`CRW_VU_LO])
    else $error("vendor bits mismatch");

  wide_field_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut |-> reqFields.wide == reqWord[`CRW_WIDTH_BIT])
    else $error("width field mismatch");

  dir_field_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut |-> reqFields.dirMsb == reqWord[`CRW_DIR_BIT])
    else $error("direction field mismatch");

  path_field_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut |-> reqFields.pathSel == reqWord[`CRW_PS_HI:`CRW_PS_LO])
    else $error("path selection mismatch");

  camp_field_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut |-> reqFields.campOn == reqWord[`CRW_CAMP_BIT])
    else $error("camp-on field mismatch");

  logical_split_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut && reqWord[`CRW_PS_LO]
      |-> reqFields.destAddr == reqWord[`CRW_DEST_HI:`CRW_DEST_LO] &&
          reqFields.srcAddr == reqWord[`CRW_SRC_HI:0])
    else $error("logical addresses mismatch");

  no_split_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut && !reqWord[`CRW_PS_LO]
      |-> reqFields.destAddr == '0 && reqFields.srcAddr == '0)
    else $error("addresses split outside logical mode");

  reserved_flag_a: assert property (@(posedge core_clk) disable iff (srst)
    stdOut
      |-> reqFields.pathError == (reqWord[`CRW_PS_HI] && !reqWord[`CRW_PS_LO]))
    else $error("reserved path flag mismatch");

  reset_clears_a: assert property (@(posedge core_clk)
    srst |=> !reqValid && reqWord == '0 && reqFields == '0)
    else $error("outputs not cleared by reset");

  load_lands_a: assert property (@(posedge core_clk) disable iff (srst)
    loadValid |=> state_r.cfgWord == $past(loadWord))
    else $error("load not taken");

  cfg_holds_a: assert property (@(posedge core_clk) disable iff (srst)
    !loadValid |=> state_r.cfgWord == $past(state_r.cfgWord))
    else $error("configured word changed without load");

  // Load then a request on the next edge: everything but the width bit arrives
  sequence loadThenReq_q;
    loadValid ##1 (connReq && !loadValid);
  endsequence

  sequence wordFromLoad_q;
    ##1 {reqWord[`CRW_WORD_W-1:`CRW_WIDTH_BIT+1], reqWord[`CRW_WIDTH_BIT-1:0]} ==
      {$past(loadWord[`CRW_WORD_W-1:`CRW_WIDTH_BIT+1], 2),
       $past(loadWord[`CRW_WIDTH_BIT-1:0], 2)};
  endsequence

  property loadUsed_p;
    @(posedge core_clk) disable iff (srst) loadThenReq_q |-> wordFromLoad_q;
  endproperty

  load_used_a: assert property (loadUsed_p)
    else $error("loaded word not sent");

  local_whole_a: assert property (@(posedge core_clk) disable iff (srst)
    (loadValid && loadWord[`CRW_LOCAL_BIT]) ##1 (connReq && !loadValid)
      |=> reqWord == $past(loadWord, 2))
    else $error("private word not sent whole");

endmodule // connection_request_field_codec

// File: crq_far_end.sv
`timescale 1ns/10ps

// ====================
// Switch side
module crq_far_end (
  // Clock
  input wire logic core_clk,
  // Word from the source
  input wire logic reqValid,
  input wire logic [31:0] reqWord,
  // Word as the switch kept it
  output logic [31:0] seenWord
);
  // Kept whole; vendor bits are never looked at or changed
  always_ff @(posedge core_clk) begin
    if (reqValid) begin
      seenWord <= reqWord;
    end
  end
endmodule // crq_far_end

// File: connection_request_field_codec_bench.sv
`timescale 1ns/10ps

// ====================
// Bench
module connection_request_field_codec_bench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic loadValid = 1'b0;
  logic [31:0] loadWord = 32'h0;
  logic busWide = 1'b1;
  logic connReq = 1'b0;
  logic reqValid;
  logic [31:0] reqWord;
  logic [31:0] seenWord;
  conn_req_pkg::req_fields_s reqFields;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  connection_request_field_codec u_connection_request_field_codec (.core_clk(core_clk),
    .srst(srst), .loadValid(loadValid), .loadWord(loadWord), .busWide(busWide),
    .connReq(connReq), .reqValid(reqValid), .reqWord(reqWord), .reqFields(reqFields));
  crq_far_end u_crq_far_end (.core_clk(core_clk), .reqValid(reqValid), .reqWord(reqWord),
    .seenWord(seenWord));

  task automatic conclude();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few dozen cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  // Local format hides every standard field
  function automatic conn_req_pkg::req_fields_s dec(input logic [31:0] w);
    if (w[31]) begin
      return {1'b1, 56'h0};
    end
    return {w[31:0], w[25] ? w[23:0] : 24'h0, w[26:25] == 2'h2};
  endfunction

  // ====================
  // Drivers, entered at a falling edge
  task automatic load(input logic [31:0] w);
    loadWord = w;
    loadValid = 1'b1;
    @(negedge core_clk);
    loadValid = 1'b0;
  endtask

  // Request stays high so calls may run back to back
  task automatic send(input logic [31:0] w);
    connReq = 1'b1;
    @(negedge core_clk);
    chk(64'(reqValid), 64'h1);
    chk(64'(reqWord), 64'(w));
    chk(64'(reqFields), 64'(dec(w)));
  endtask

  task automatic idle();
    connReq = 1'b0;
    @(negedge core_clk);
    chk(64'(reqValid), 64'h0);
  endtask

  // ====================
  // Scenarios
  task automatic std_word();
    load(32'h4BAB_CDEF);
    send(32'h5BAB_CDEF);
    send(32'h5BAB_CDEF);
    idle();
    chk(64'(seenWord), 64'h5BAB_CDEF);
    busWide = 1'b0;
    repeat (3) @(negedge core_clk);
    send(32'h4BAB_CDEF);
    idle();
  endtask

  task automatic path_codes();
    for (int p = 0; p < 4; p++) begin
      load({5'h0, 2'(p), 1'b1, 24'h123456});
      send({5'h0, 2'(p), 1'b1, 24'h123456});
    end
    idle();
  endtask

  // Load beside a request: the older word still goes out
  task automatic local_word();
    load(32'hF400_0001);
    send(32'hF400_0001);
    loadWord = 32'h0;
    loadValid = 1'b1;
    send(32'hF400_0001);
    loadValid = 1'b0;
    send(32'h0);
    idle();
  endtask

  // Reset in mid-run clears the configured word and the outputs
  task automatic reset_mid();
    load(32'h0F00_0000);
    srst = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(64'(reqWord), 64'h0);
    chk(64'(reqFields), 64'h0);
    srst = 1'b0;
    send(32'h0);
    idle();
  endtask

  initial begin
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    chk(64'(reqWord), 64'h0);
    std_word();
    path_codes();
    local_word();
    reset_mid();
    conclude();
  end
endmodule // connection_request_field_codec_bench
